/* shared/sies_pkg.sv */
// Register map, field layout and bus carrier of the stage interrupt enable/status block
package sies_pkg;
  localparam int STAGES = 12;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // Register offsets, used as plain addresses on the register port
  localparam logic [ADDR_W-1:0] LOW_EN_ADDR = 8'h05;
  localparam logic [ADDR_W-1:0] DONE_EN_ADDR = 8'h07;
  localparam logic [ADDR_W-1:0] LOW_FLAG_ADDR = 8'h08;
  localparam logic [ADDR_W-1:0] DONE_FLAG_ADDR = 8'h0a;

  // Field layout
  localparam int GPIO_BIT = 12;
  localparam logic [DATA_W-1:0] DONE_EN_MASK = 16'h1fff;
  localparam logic [DATA_W-1:0] LOW_EN_MASK = 16'h0fff;
  localparam logic [DATA_W-1:0] LOW_FLAG_MASK = 16'h0fff;
  localparam logic [DATA_W-1:0] DONE_FLAG_MASK = 16'h1fff;

  // Reset values
  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] READ_IDLE = 16'h0000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } sies_req_s;
endpackage : sies_pkg

/* rtl/sies_stage_irq.sv */
// Stage completion / low-limit interrupt enables, sticky status and interrupt line
// Function
// - Completion enable register, stages 0-11, reset zero.
// - Enabled stage completion asserts the interrupt.
// - Bit 12 enables GPIO level-change interrupt.
// - Low-limit flags, stages 0-11, reset zero, also cleared by a one-to-clear write.
// - Low threshold passed sets stage low flag.
// - Reading flags clears them unless still exceeded.
// - Low-threshold enable register gates low-limit interrupts.
`timescale 1ns/1ps
module sies_stage_irq #(
  parameter int STAGES = sies_pkg::STAGES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire sies_pkg::sies_req_s regReq,
  output logic [sies_pkg::DATA_W-1:0] rdData,
  input wire logic [STAGES-1:0] stageDone,
  input wire logic [STAGES-1:0] lowExceeded,
  input wire logic gpioIn,
  output logic irq_n
);

  logic [sies_pkg::DATA_W-1:0] doneEnable;
  logic [STAGES-1:0] lowEnable;
  logic [STAGES-1:0] lowFlags;
  logic [STAGES-1:0] doneFlags;
  logic gpioFlag;
  logic gpioMeta;
  logic gpioSync;
  logic gpioPrev;
  logic gpioChange;
  logic anyPending;

  function automatic logic hit(input sies_pkg::sies_req_s r, input logic [sies_pkg::ADDR_W-1:0] a);
    hit = r.addr == a;
  endfunction : hit

  // Unused upper bits are dropped, so stray ones from the host are harmless
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      doneEnable <= sies_pkg::REG_RESET;
    end else if (regReq.wr && hit(regReq, sies_pkg::DONE_EN_ADDR)) begin
      doneEnable <= regReq.wdata & sies_pkg::DONE_EN_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lowEnable <= '0;
    end else if (regReq.wr && hit(regReq, sies_pkg::LOW_EN_ADDR)) begin
      lowEnable <= regReq.wdata[STAGES-1:0];
    end
  end

  // GPIO pin crosses in through two flops; a change is the second one differing from a third, delayed flop
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gpioMeta <= 1'b0;
      gpioSync <= 1'b0;
      gpioPrev <= 1'b0;
    end else begin
      gpioMeta <= gpioIn;
      gpioSync <= gpioMeta;
      gpioPrev <= gpioSync;
    end
  end

  assign gpioChange = gpioSync != gpioPrev;

  logic readLow;
  logic readDone;
  logic clrLowW;
  logic clrDoneW;
  assign readLow = regReq.rd && hit(regReq, sies_pkg::LOW_FLAG_ADDR);
  assign readDone = regReq.rd && hit(regReq, sies_pkg::DONE_FLAG_ADDR);
  assign clrLowW = regReq.wr && hit(regReq, sies_pkg::LOW_FLAG_ADDR);
  assign clrDoneW = regReq.wr && hit(regReq, sies_pkg::DONE_FLAG_ADDR);

  logic [STAGES-1:0] lowClr;
  logic [STAGES-1:0] doneClr;
  logic gpioClr;
  always_comb begin
    lowClr = '0;
    doneClr = '0;
    gpioClr = 1'b0;
    if (readLow) begin
      lowClr = '1;
    end
    if (clrLowW) begin
      lowClr = regReq.wdata[STAGES-1:0];
    end
    if (readDone) begin
      doneClr = '1;
      gpioClr = 1'b1;
    end
    if (clrDoneW) begin
      doneClr = regReq.wdata[STAGES-1:0];
      gpioClr = regReq.wdata[sies_pkg::GPIO_BIT];
    end
  end

  // Set wins over clear, so a level still past its limit survives a read
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lowFlags <= '0;
    end else begin
      lowFlags <= (lowFlags & ~lowClr) | lowExceeded;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      doneFlags <= '0;
      gpioFlag <= 1'b0;
    end else begin
      doneFlags <= (doneFlags & ~doneClr) | stageDone;
      gpioFlag <= (gpioFlag & ~gpioClr) | gpioChange;
    end
  end

  // Read data are only valid in the cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= sies_pkg::READ_IDLE;
    end else if (regReq.rd) begin
      unique case (regReq.addr)
        sies_pkg::LOW_EN_ADDR: rdData <= sies_pkg::DATA_W'(lowEnable);
        sies_pkg::DONE_EN_ADDR: rdData <= doneEnable;
        sies_pkg::LOW_FLAG_ADDR: rdData <= sies_pkg::DATA_W'(lowFlags);
        sies_pkg::DONE_FLAG_ADDR: rdData <= sies_pkg::DATA_W'({gpioFlag, doneFlags});
        default: rdData <= sies_pkg::READ_IDLE;
      endcase
    end else begin
      rdData <= sies_pkg::READ_IDLE;
    end
  end

  assign anyPending = |(doneFlags & doneEnable[STAGES-1:0])
                    | (gpioFlag & doneEnable[sies_pkg::GPIO_BIT])
                    | |(lowFlags & lowEnable);

  // Registered so the pin never glitches while flags and enables move together
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~anyPending;
    end
  end

  property p_done_en_write;
    @(posedge core_clk) disable iff (!rst_n)
      regReq.wr && regReq.addr == sies_pkg::DONE_EN_ADDR
      |=> doneEnable == ($past(regReq.wdata) & sies_pkg::DONE_EN_MASK);
  endproperty
  a_done_en_write: assert property (p_done_en_write) else $error("completion enable write lost");

  property p_done_irq;
    @(posedge core_clk) disable iff (!rst_n)
      |(stageDone & doneEnable[STAGES-1:0]) && !regReq.wr |-> ##[1:3] !irq_n;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("enabled completion gave no interrupt");

  property p_gpio_irq;
    @(posedge core_clk) disable iff (!rst_n)
      gpioChange && doneEnable[sies_pkg::GPIO_BIT] && !regReq.wr |-> ##[1:3] !irq_n;
  endproperty
  a_gpio_irq: assert property (p_gpio_irq) else $error("enabled gpio change gave no interrupt");

  property p_low_read;
    @(posedge core_clk) disable iff (!rst_n)
      regReq.rd && regReq.addr == sies_pkg::LOW_FLAG_ADDR
      |=> rdData == sies_pkg::DATA_W'($past(lowFlags));
  endproperty
  a_low_read: assert property (p_low_read) else $error("low flag readback wrong");

  property p_low_set;
    @(posedge core_clk) disable iff (!rst_n)
      lowExceeded != '0 |=> (lowFlags & $past(lowExceeded)) == $past(lowExceeded);
  endproperty
  a_low_set: assert property (p_low_set) else $error("low flag not set");

  property p_low_clear;
    @(posedge core_clk) disable iff (!rst_n)
      regReq.rd && regReq.addr == sies_pkg::LOW_FLAG_ADDR |=> lowFlags == $past(lowExceeded);
  endproperty
  a_low_clear: assert property (p_low_clear) else $error("low flags not cleared by read");

  property p_done_clear;
    @(posedge core_clk) disable iff (!rst_n)
      regReq.rd && regReq.addr == sies_pkg::DONE_FLAG_ADDR && stageDone == '0 && !gpioChange
      |=> doneFlags == '0 && !gpioFlag;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("completion flags not cleared by read");

  property p_low_irq;
    @(posedge core_clk) disable iff (!rst_n)
      |(lowExceeded & lowEnable) && !regReq.wr |-> ##[1:2] !irq_n;
  endproperty
  a_low_irq: assert property (p_low_irq) else $error("enabled low limit gave no interrupt");

  property p_quiet;
    @(posedge core_clk) disable iff (!rst_n)
      (doneEnable == '0 && lowEnable == '0) [*3] |-> irq_n;
  endproperty
  a_quiet: assert property (p_quiet) else $error("interrupt with all sources disabled");

  // Enables only move on a write to their own address
  property p_done_en_hold;
    @(posedge core_clk) disable iff (!rst_n)
      !(regReq.wr && regReq.addr == sies_pkg::DONE_EN_ADDR) |=> $stable(doneEnable);
  endproperty
  a_done_en_hold: assert property (p_done_en_hold) else $error("completion enable moved without write");

  property p_done_en_read;
    @(posedge core_clk) disable iff (!rst_n)
      regReq.rd && regReq.addr == sies_pkg::DONE_EN_ADDR |=> rdData == $past(doneEnable);
  endproperty
  a_done_en_read: assert property (p_done_en_read) else $error("completion enable readback wrong");

  property p_upper_zero;
    @(posedge core_clk) disable iff (!rst_n)
      rdData[sies_pkg::DATA_W-1:sies_pkg::GPIO_BIT+1] == '0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("unused read bits not zero");

  property p_low_en_write;
    @(posedge core_clk) disable iff (!rst_n)
      regReq.wr && regReq.addr == sies_pkg::LOW_EN_ADDR |=> lowEnable == $past(regReq.wdata[STAGES-1:0]);
  endproperty
  a_low_en_write: assert property (p_low_en_write) else $error("low enable write lost");

  property p_low_en_hold;
    @(posedge core_clk) disable iff (!rst_n)
      !(regReq.wr && regReq.addr == sies_pkg::LOW_EN_ADDR) |=> $stable(lowEnable);
  endproperty
  a_low_en_hold: assert property (p_low_en_hold) else $error("low enable moved without write");

  // Flags are sticky: only a read or a one-to-clear write may drop a bit
  property p_done_set;
    @(posedge core_clk) disable iff (!rst_n)
      stageDone != '0 |=> (doneFlags & $past(stageDone)) == $past(stageDone);
  endproperty
  a_done_set: assert property (p_done_set) else $error("completion flag not set");

  property p_done_keep;
    @(posedge core_clk) disable iff (!rst_n)
      !readDone && !clrDoneW
      |=> (doneFlags & $past(doneFlags)) == $past(doneFlags) && (gpioFlag || !$past(gpioFlag));
  endproperty
  a_done_keep: assert property (p_done_keep) else $error("completion flag dropped without clear");

  property p_gpio_sync;
    @(posedge core_clk) disable iff (!rst_n)
      gpioSync == $past(gpioMeta);
  endproperty
  a_gpio_sync: assert property (p_gpio_sync) else $error("gpio synchroniser skipped a stage");

  property p_gpio_set;
    @(posedge core_clk) disable iff (!rst_n)
      gpioChange |=> gpioFlag;
  endproperty
  a_gpio_set: assert property (p_gpio_set) else $error("gpio change flag not set");

  property p_done_flag_read;
    @(posedge core_clk) disable iff (!rst_n)
      regReq.rd && regReq.addr == sies_pkg::DONE_FLAG_ADDR
      |=> rdData == sies_pkg::DATA_W'({$past(gpioFlag), $past(doneFlags)});
  endproperty
  a_done_flag_read: assert property (p_done_flag_read) else $error("completion flag readback wrong");

  property p_read_idle;
    @(posedge core_clk) disable iff (!rst_n)
      !regReq.rd |=> rdData == sies_pkg::READ_IDLE;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data outside the answer cycle");

  property p_low_keep;
    @(posedge core_clk) disable iff (!rst_n)
      !readLow && !clrLowW |=> (lowFlags & $past(lowFlags)) == $past(lowFlags);
  endproperty
  a_low_keep: assert property (p_low_keep) else $error("low flag dropped without clear");

  property p_irq_set;
    @(posedge core_clk) disable iff (!rst_n)
      anyPending |=> !irq_n;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("pending source left interrupt high");

  property p_irq_clear;
    @(posedge core_clk) disable iff (!rst_n)
      !anyPending |=> irq_n;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("interrupt low with nothing pending");

  c_done_irq: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(irq_n) && doneFlags != '0);
  c_low_keep: cover property (@(posedge core_clk) disable iff (!rst_n) readLow && lowExceeded != '0);
  c_gpio: cover property (@(posedge core_clk) disable iff (!rst_n) gpioFlag && !irq_n);
  c_release: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(irq_n));
  c_w1c: cover property (@(posedge core_clk) disable iff (!rst_n) clrDoneW && regReq.wdata != '0);

endmodule : sies_stage_irq

/* verif/sies_conv_model.sv */
// Conversion-side stand-in that drives the stage events into the block
`timescale 1ns/1ps
module sies_conv_model (
  input wire logic core_clk,
  input wire logic [11:0] doneCmd,
  input wire logic [11:0] lowCmd,
  input wire logic gpioCmd,
  output logic [11:0] stageDone = 12'h000,
  output logic [11:0] lowExceeded = 12'h000,
  output logic gpioIn = 1'b0
);
  // Completion is a one-cycle pulse, so a held command cannot re-arm the flag
  logic [11:0] prevDone = 12'h000;
  always @(posedge core_clk) begin
    prevDone <= doneCmd;
    stageDone <= doneCmd & ~prevDone;
    lowExceeded <= lowCmd;
    gpioIn <= gpioCmd;
  end
endmodule : sies_conv_model

/* verif/sies_stage_irq_tb_top.sv */
// Register-level self-checking bench for the stage interrupt block
`timescale 1ns/1ps
module sies_stage_irq_tb_top;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  sies_pkg::sies_req_s regReq = '0;
  logic [15:0] rdData;
  logic [11:0] stageDone, lowExceeded;
  logic [11:0] doneCmd = 12'h000;
  logic [11:0] lowCmd = 12'h000;
  logic gpioIn, irq_n;
  logic gpioCmd = 1'b0;
  int error_cnt = 0;
  int n_checks = 0;
  always #12.5 core_clk = ~core_clk;
  sies_conv_model conv (.core_clk(core_clk), .doneCmd(doneCmd), .lowCmd(lowCmd), .gpioCmd(gpioCmd),
    .stageDone(stageDone), .lowExceeded(lowExceeded), .gpioIn(gpioIn));
  sies_stage_irq dut (.core_clk(core_clk), .rst_n(rst_n), .regReq(regReq), .rdData(rdData),
    .stageDone(stageDone), .lowExceeded(lowExceeded), .gpioIn(gpioIn), .irq_n(irq_n));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    regReq.wr <= 1'b0;
  endtask : wr
  task automatic rdChk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    regReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    regReq.rd <= 1'b0;
    #1 chk(rdData, exp);
  endtask : rdChk
  // Bounded wait; running out shows up as a mismatch on the line level
  task automatic waitIrq(input logic exp);
    for (int i = 0; i < 8 && irq_n !== exp; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk({15'h0000, irq_n}, {15'h0000, exp});
  endtask : waitIrq
  task automatic final_report;
    $display("checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rdChk(sies_pkg::DONE_EN_ADDR, 16'h0000);
    rdChk(sies_pkg::LOW_FLAG_ADDR, 16'h0000);
    rdChk(8'h30, 16'h0000);
    waitIrq(1'b1);
    $display("test reset done");
    wr(sies_pkg::DONE_EN_ADDR, 16'h1fff);
    rdChk(sies_pkg::DONE_EN_ADDR, 16'h1fff);
    wr(sies_pkg::DONE_EN_ADDR, 16'h0008);
    doneCmd <= 12'h028;
    waitIrq(1'b0);
    rdChk(sies_pkg::DONE_FLAG_ADDR, 16'h0028);
    doneCmd <= 12'h000;
    waitIrq(1'b1);
    repeat (2) @(posedge core_clk);
    doneCmd <= 12'h020;
    repeat (6) @(posedge core_clk);
    chk({15'h0000, irq_n}, 16'h0001);
    rdChk(sies_pkg::DONE_FLAG_ADDR, 16'h0020);
    doneCmd <= 12'h000;
    repeat (2) @(posedge core_clk);
    doneCmd <= 12'h030;
    repeat (3) @(posedge core_clk);
    wr(sies_pkg::DONE_FLAG_ADDR, 16'h0010);
    rdChk(sies_pkg::DONE_FLAG_ADDR, 16'h0020);
    $display("test completion done");
    wr(sies_pkg::DONE_EN_ADDR, 16'h1000);
    gpioCmd <= 1'b1;
    waitIrq(1'b0);
    rdChk(sies_pkg::DONE_FLAG_ADDR, 16'h1000);
    waitIrq(1'b1);
    $display("test gpio done");
    wr(sies_pkg::LOW_EN_ADDR, 16'h0001);
    lowCmd <= 12'h001;
    waitIrq(1'b0);
    rdChk(sies_pkg::LOW_FLAG_ADDR, 16'h0001);
    rdChk(sies_pkg::LOW_FLAG_ADDR, 16'h0001);
    lowCmd <= 12'h000;
    repeat (3) @(posedge core_clk);
    rdChk(sies_pkg::LOW_FLAG_ADDR, 16'h0001);
    rdChk(sies_pkg::LOW_FLAG_ADDR, 16'h0000);
    waitIrq(1'b1);
    rdChk(sies_pkg::LOW_EN_ADDR, 16'h0001);
    lowCmd <= 12'h002;
    repeat (2) @(posedge core_clk);
    lowCmd <= 12'h000;
    repeat (2) @(posedge core_clk);
    wr(sies_pkg::LOW_FLAG_ADDR, 16'h0002);
    rdChk(sies_pkg::LOW_FLAG_ADDR, 16'h0000);
    $display("test low limit done");
    final_report();
  end
endmodule : sies_stage_irq_tb_top
